// ==== rtl/reset_ctrl_pkg.sv ====
package reset_ctrl_pkg;

   // reset sequence timing; the hold time is set in ns and converted to core clock cycles
   localparam int unsigned CLOCK_HZ = 10_000_000;
   localparam int unsigned MIN_REQ_CYCLES = 2;
   localparam int unsigned RESET_HOLD_NS = 1000;
   localparam int unsigned RESET_HOLD_CYCLES =
      (RESET_HOLD_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned CAL_CYCLES = 64;
   localparam int unsigned SYNC_STAGES = 2;

   typedef enum logic [3:0] {
      ST_RESET = 4'h1,
      ST_CAL   = 4'h2,
      ST_READY = 4'h4,
      ST_WAIT  = 4'h8
   } seq_state_t;

   // status carried to the user side and to the phy reset
   typedef struct packed {
      logic done;
      logic in_reset;
      logic calibrating;
   } seq_status_t;

endpackage : reset_ctrl_pkg

// ==== rtl/req_sync.sv ====
`timescale 1ns/1ns
// synchroniser plus rising-edge and pulse-width qualifier for the request
module req_sync #(
   parameter int unsigned STAGES = 2,
   parameter int unsigned MIN_HIGH = 2
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clock_en,
   // request
   input wire logic req_in,
   output logic req_valid
);

   logic [STAGES-1:0] sync;
   logic [STAGES-1:0] next_sync;
   logic [7:0] high_count;
   logic [7:0] next_high_count;
   logic next_req_valid;
   logic req_s;

   assign req_s = sync[STAGES-1];

   always_comb begin
      next_sync = {sync[STAGES-2:0], req_in};
      next_req_valid = 1'b0;
      next_high_count = high_count;
      if (!req_s) begin
         next_high_count = 8'h00;
      end else if (high_count < 8'(MIN_HIGH)) begin
         next_high_count = high_count + 8'h01;
         // fires once per pulse, as soon as the pulse has lasted long enough
         next_req_valid = (high_count == 8'(MIN_HIGH - 1));
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sync <= '0;
         high_count <= 8'h00;
         req_valid <= 1'b0;
      end else if (clock_en) begin
         sync <= next_sync;
         high_count <= next_high_count;
         req_valid <= next_req_valid;
      end
   end

endmodule : req_sync

// ==== rtl/memory_interface_reset_control.sv ====
`timescale 1ns/1ns
// How it works
// R1: a low column reset resets the interface at once, then a full recalibration runs.
// R2: the column reset port is shared by all interfaces in one column and acts on each.
// R3: user logic requests a reset with a low-high-low pulse at least 2 cycles high.
// R4: a valid request pulse resets the interface and then recalibrates it.
// R5: the request is synchronised inside and a pulse of 2 or more cycles is taken only while done is high.
// R6: done rises only once reset and calibration finished and a new request can be taken.
// R7: done stays low for as long as the interface is held in reset.
// R8: the phy reset output asserts asynchronously and releases on the clock edge; rst_b and requests assert it on the clock edge instead.
// R9: done falls in the cycle a request is recognised, and requests are ignored until done.
module memory_interface_reset_control #(
   parameter int unsigned HOLD_CYCLES = reset_ctrl_pkg::RESET_HOLD_CYCLES,
   parameter int unsigned CAL_CYCLES = reset_ctrl_pkg::CAL_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clock_en,
   // column-wide reset, active low, asynchronous
   input wire logic column_reset_b,
   // user request and status
   input wire logic soft_reinit_req,
   output logic soft_reinit_done,
   output logic cal_busy,
   // phy domain reset
   output logic phy_reset_b
);

   reset_ctrl_pkg::seq_state_t state;
   reset_ctrl_pkg::seq_state_t next_state;
   logic [15:0] count;
   logic [15:0] next_count;
   logic next_done;
   logic next_busy;
   logic next_phy_reset_b;
   logic req_valid;
   // column release pipeline; only the last stage feeds the state machine
   logic [reset_ctrl_pkg::SYNC_STAGES-1:0] col_pipe;
   logic [reset_ctrl_pkg::SYNC_STAGES-1:0] next_col_pipe;
   logic col_sync_b;
   // status of the next state, carried as one word before it fans out to the pins
   reset_ctrl_pkg::seq_status_t next_status;

   // last count value of a timed state; the event-driven states never reach it
   function automatic logic [15:0] stage_last(input reset_ctrl_pkg::seq_state_t s);
      logic [15:0] last;
      last = 16'h0000;
      case (s)
         reset_ctrl_pkg::ST_RESET: begin
            last = 16'(HOLD_CYCLES - 1);
         end
         reset_ctrl_pkg::ST_CAL: begin
            last = 16'(CAL_CYCLES - 1);
         end
         default: begin
            last = 16'h0000;
         end
      endcase
      return last;
   endfunction : stage_last

   // state entered once a timed state has run its count out
   function automatic reset_ctrl_pkg::seq_state_t stage_after(
      input reset_ctrl_pkg::seq_state_t s
   );
      reset_ctrl_pkg::seq_state_t after;
      after = reset_ctrl_pkg::ST_RESET;
      case (s)
         reset_ctrl_pkg::ST_RESET: begin
            after = reset_ctrl_pkg::ST_CAL;
         end
         reset_ctrl_pkg::ST_CAL: begin
            after = reset_ctrl_pkg::ST_READY;
         end
         default: begin
            after = reset_ctrl_pkg::ST_RESET;
         end
      endcase
      return after;
   endfunction : stage_after

   // pin-level status of a state; done is high only when a new request can be taken
   function automatic reset_ctrl_pkg::seq_status_t status_of(
      input reset_ctrl_pkg::seq_state_t s
   );
      reset_ctrl_pkg::seq_status_t st;
      st.done = (s == reset_ctrl_pkg::ST_READY);
      st.in_reset = (s == reset_ctrl_pkg::ST_RESET);
      st.calibrating = (s == reset_ctrl_pkg::ST_CAL);
      return st;
   endfunction : status_of

   req_sync #(
      .STAGES(reset_ctrl_pkg::SYNC_STAGES),
      .MIN_HIGH(reset_ctrl_pkg::MIN_REQ_CYCLES)
   ) req_sync_inst (
      .clock(clock),
      .rst_b(rst_b),
      .clock_en(clock_en),
      .req_in(soft_reinit_req), // [R5] [R3]
      .req_valid(req_valid)
   );

   // column reset is a true async reset: clear at once, release through a short pipeline
   // each stage copies the one before it; stage 0 takes the released level
   genvar g;
   generate
      for (g = 0; g < reset_ctrl_pkg::SYNC_STAGES; g++) begin : g_col_stage
         if (g == 0) begin : g_first
            assign next_col_pipe[g] = 1'b1;
         end else begin : g_rest
            assign next_col_pipe[g] = col_pipe[g-1];
         end
      end
   endgenerate

   // a low clock enable also holds the release, so no stage runs while frozen
   always_ff @(posedge clock or negedge column_reset_b) begin
      if (!column_reset_b) begin // [R1] [R2]
         col_pipe <= '0;
      end else if (clock_en) begin
         col_pipe <= next_col_pipe;
      end
   end

   // the state machine only ever sees the synchronised release
   assign col_sync_b = col_pipe[reset_ctrl_pkg::SYNC_STAGES-1];

   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         reset_ctrl_pkg::ST_RESET: begin
            if (count >= stage_last(state)) begin
               next_state = stage_after(state); // [R4]
               next_count = 16'h0000;
            end else begin
               next_count = count + 16'h0001;
            end
         end
         reset_ctrl_pkg::ST_CAL: begin
            if (count >= stage_last(state)) begin
               next_state = stage_after(state); // [R1]
               next_count = 16'h0000;
            end else begin
               next_count = count + 16'h0001;
            end
         end
         reset_ctrl_pkg::ST_READY: begin
            // pulses seen while not ready are dropped on purpose
            if (req_valid) begin // [R9]
               next_state = reset_ctrl_pkg::ST_RESET; // [R4]
               next_count = 16'h0000;
            end
         end
         reset_ctrl_pkg::ST_WAIT: begin
            // spare code, never entered; handled like a lost state
            next_state = reset_ctrl_pkg::ST_RESET;
            next_count = 16'h0000;
         end
         default: begin
            next_state = reset_ctrl_pkg::ST_RESET;
            next_count = 16'h0000;
         end
      endcase
   end

   // status group: decoded from the next state, so done drops in the cycle of the request
   always_comb begin
      next_status = status_of(next_state);
      next_done = next_status.done; // [R6] [R7] [R9]
      next_busy = next_status.calibrating;
      next_phy_reset_b = !next_status.in_reset; // [R8]
   end

   // column reset forces the reset state asynchronously; the soft reset stays synchronous
   always_ff @(posedge clock or negedge col_sync_b) begin
      if (!col_sync_b) begin // [R1]
         state <= reset_ctrl_pkg::ST_RESET;
         count <= 16'h0000;
      end else if (!rst_b) begin
         state <= reset_ctrl_pkg::ST_RESET;
         count <= 16'h0000;
      end else if (clock_en) begin
         state <= next_state;
         count <= next_count;
      end
   end

   // pins are registered from the next state, so they change together with the state
   always_ff @(posedge clock or negedge col_sync_b) begin
      if (!col_sync_b) begin // [R1]
         soft_reinit_done <= 1'b0; // [R7]
         cal_busy <= 1'b0;
         phy_reset_b <= 1'b0; // [R8]
      end else if (!rst_b) begin
         soft_reinit_done <= 1'b0;
         cal_busy <= 1'b0;
         phy_reset_b <= 1'b0;
      end else if (clock_en) begin
         soft_reinit_done <= next_done;
         cal_busy <= next_busy;
         phy_reset_b <= next_phy_reset_b; // [R8]
      end
   end

endmodule : memory_interface_reset_control

// ==== sim/rc_sva.sv ====
`timescale 1ns/1ns
module rc_sva (
   // clock and resets
   input wire logic clock,
   input wire logic rst_b,
   input wire logic column_reset_b,
   // user side and phy
   input wire logic soft_reinit_req,
   input wire logic soft_reinit_done,
   input wire logic cal_busy,
   input wire logic phy_reset_b
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // a fresh request held for two samples while idle
   sequence req_seen;
      $rose(soft_reinit_req) && soft_reinit_done ##1 soft_reinit_req;
   endsequence
   chk_col_drop: assert property (!column_reset_b |-> !soft_reinit_done && !phy_reset_b)
      else $error("column reset");
   chk_req_drop: assert property (req_seen |-> ##[1:6] !soft_reinit_done)
      else $error("request");
   chk_phy_done: assert property (!phy_reset_b |-> !soft_reinit_done)
      else $error("done in reset");
   chk_busy_done: assert property (cal_busy |-> !soft_reinit_done && phy_reset_b)
      else $error("done in cal");
   chk_hold_len: assert property ($fell(soft_reinit_done) && column_reset_b |->
      !phy_reset_b[*4] ##1 phy_reset_b && cal_busy) else $error("hold");
   chk_cal_len: assert property ($rose(cal_busy) |-> cal_busy[*8] ##1 soft_reinit_done)
      else $error("cal");
   chk_phy_sync: assert property ($rose(phy_reset_b) |-> $past(column_reset_b, 2))
      else $error("phy release");
   chk_done_rise: assert property ($rose(soft_reinit_done) |-> $past(cal_busy))
      else $error("done rise");
endmodule : rc_sva

bind memory_interface_reset_control rc_sva rc_sva_inst (.clock(clock), .rst_b(rst_b),
   .column_reset_b(column_reset_b), .soft_reinit_req(soft_reinit_req),
   .soft_reinit_done(soft_reinit_done), .cal_busy(cal_busy), .phy_reset_b(phy_reset_b));

// ==== sim/user_req_model.sv ====
`timescale 1ns/1ns
module user_req_model (
   input wire logic clock,
   input wire logic go,
   input wire logic [3:0] width,
   output logic req
);
   logic [3:0] cnt = 4'h0;
   // low-high-low pulse of width cycles, idle low between pulses
   always @(posedge clock) begin
      if (go) cnt <= width;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
   end
   assign req = (cnt != 4'h0);
endmodule : user_req_model

// ==== sim/memory_interface_reset_control_bench.sv ====
`timescale 1ns/1ns
module memory_interface_reset_control_bench;
   logic clock = 1'b0, rst_b = 1'b0, col_b = 1'b1, go = 1'b0;
   logic [3:0] width = 4'h2;
   logic done, busy, phy_b, req;
   int err_count = 0, check_count = 0;
   always #50 clock = ~clock;
   user_req_model user_req_model_inst (.clock(clock), .go(go), .width(width), .req(req));
   memory_interface_reset_control #(.HOLD_CYCLES(4), .CAL_CYCLES(8))
      memory_interface_reset_control_inst (.clock(clock), .rst_b(rst_b), .clock_en(1'b1),
      .column_reset_b(col_b), .soft_reinit_req(req), .soft_reinit_done(done),
      .cal_busy(busy), .phy_reset_b(phy_b));
   task check(input string name, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask : check
   task wait_done(input logic v);
      int i;
      i = 0;
      while (done !== v && i < 40) begin
         @(posedge clock);
         #1;
         i++;
      end
      check("done", v, done);
   endtask : wait_done
   task pulse(input logic [3:0] w);
      @(posedge clock);
      width <= w;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
   endtask : pulse
   // a second pulse while calibrating must not stretch the sequence
   task t_request(input logic [3:0] w);
      pulse(w);
      wait_done(1'b0);
      check("phy", 1'b0, phy_b);
      repeat (2) @(posedge clock);
      pulse(4'h3);
      repeat (3) @(posedge clock);
      #1;
      check("busy", 1'b1, busy);
      wait_done(1'b1);
      repeat (12) @(posedge clock);
      check("done", 1'b1, done);
      $display("request width %0d finished", w);
   endtask : t_request
   task t_column;
      @(posedge clock);
      col_b <= 1'b0;
      #1;
      check("done", 1'b0, done);
      check("phy", 1'b0, phy_b);
      check("busy", 1'b0, busy);
      repeat (3) @(posedge clock);
      col_b <= 1'b1;
      wait_done(1'b1);
      $display("column reset finished");
   endtask : t_column
   task conclude;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   initial begin
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      wait_done(1'b1);
      t_request(4'h2);
      t_request(4'h6);
      t_column();
      conclude();
   end
   initial begin
      #(600 * 100);
      err_count++;
      conclude();
   end
endmodule : memory_interface_reset_control_bench
